// >>> design/adcsq_cfg.svh
// constants for the auxiliary converter sequencer
`ifndef ADCSQ_CFG_SVH
`define ADCSQ_CFG_SVH

`define ADCSQ_CLK_HZ 64'd100000000
`define ADCSQ_SAMPLE_W 16
`define ADCSQ_ENOB_FAST 10
`define ADCSQ_NUM_CHAN 9
// channels that are a bonded pair of two pads
`define ADCSQ_PAIR_MASK 9'h064

// sample rate caps per mode, in millihertz
`define ADCSQ_RATE0_MHZ 64'd5859000
`define ADCSQ_RATE1_MHZ 64'd11700000
`define ADCSQ_RATE2_MHZ 64'd46875000
`define ADCSQ_RATE3_MHZ 64'd93750000
`define ADCSQ_RATE4_MHZ 64'd187000000

// settling latency per mode, in microseconds
`define ADCSQ_SETTLE0_US 64'd171
`define ADCSQ_SETTLE1_US 64'd85
`define ADCSQ_SETTLE2_US 64'd21
`define ADCSQ_SETTLE3_US 64'd11
`define ADCSQ_SETTLE4_US 64'd5

// longest conversion time, in microseconds
`define ADCSQ_CONV_US 64'd10

// least sample period in cycles, rounded up
`define ADCSQ_MIN_CYC(mhz) ((`ADCSQ_CLK_HZ * 64'd1000 + (mhz) - 64'd1) / (mhz))
// least time in cycles, rounded up
`define ADCSQ_US_MIN_CYC(us) (((us) * `ADCSQ_CLK_HZ + 64'd999999) / 64'd1000000)
// longest time in cycles, rounded down
`define ADCSQ_US_MAX_CYC(us) (((us) * `ADCSQ_CLK_HZ) / 64'd1000000)

// reset values
`define ADCSQ_RST_CHAN 4'h0
`define ADCSQ_RST_MODE 3'h0
`define ADCSQ_RST_RANGE 2'h0

`endif

// >>> design/adcsq_pkg.sv
// types shared by the converter sequencer
package adcsq_pkg;

  typedef enum logic [1:0] {
    ADCSQ_IDLE,
    ADCSQ_SETTLE,
    ADCSQ_CONVERT
  } adcsq_state_type;

  // input range codes: 0-3.6 V, 0-2.4 V, 0-1.2 V
  typedef enum logic [1:0] {
    ADCSQ_RANGE_3V6 = 2'h0,
    ADCSQ_RANGE_2V4 = 2'h1,
    ADCSQ_RANGE_1V2 = 2'h2
  } adcsq_range_type;

endpackage

// >>> design/adcsq_timer.sv
// down-counting interval timer, done once the loaded cycles have elapsed
`timescale 1ns/1ns

module adcsq_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic load,
  input wire logic [W-1:0] cycles,
  output logic done
);

  logic [W-1:0] cnt_reg;

  // loading n makes done rise exactly n cycles later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (ce) begin
      if (load) begin
        cnt_reg <= (cycles == '0) ? '0 : cycles - W'(1);
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - W'(1);
      end
    end
  end

  assign done = (cnt_reg == '0);

endmodule

// >>> design/adcsq_top.sv
// sequencer and sample path of the auxiliary analog-to-digital converter
`timescale 1ns/1ns
`include "adcsq_cfg.svh"

// What this block does
// [R1] Samples are 16-bit words, cut to their ten effective bits in the fastest mode.
// [R2] One of nine channels is selected one-hot, and a bonded pair yields only one pad.
// [R3] A conversion is given at most ten microseconds and is abandoned after that.
// [R4] Conversions never start more often than 187 thousand times per second.
// [R5] A setting picks the supply-based or the bandgap-based reference.
// [R6] The multiplexer selects for input and reference are driven as firmware asks.
// [R7] Raw core words become valid samples only when taken from a settled channel.
// [R8] A setting picks the 3.6 V, 2.4 V or 1.2 V input range.
// [R9] Modes 0 to 4 cap the rate at 5.859, 11.7, 46.875, 93.75 and 187 kHz.
// [R10] After a channel change no sample is valid until the mode's settling time passes.
// [R11] A ready flag rises with each new valid sample and falls when it is read.

module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int CW = 16,
  parameter int unsigned PER0 = int'(`ADCSQ_MIN_CYC(`ADCSQ_RATE0_MHZ)),
  parameter int unsigned PER1 = int'(`ADCSQ_MIN_CYC(`ADCSQ_RATE1_MHZ)),
  parameter int unsigned PER2 = int'(`ADCSQ_MIN_CYC(`ADCSQ_RATE2_MHZ)),
  parameter int unsigned PER3 = int'(`ADCSQ_MIN_CYC(`ADCSQ_RATE3_MHZ)),
  parameter int unsigned PER4 = int'(`ADCSQ_MIN_CYC(`ADCSQ_RATE4_MHZ)),
  parameter int unsigned SET0 = int'(`ADCSQ_US_MIN_CYC(`ADCSQ_SETTLE0_US)),
  parameter int unsigned SET1 = int'(`ADCSQ_US_MIN_CYC(`ADCSQ_SETTLE1_US)),
  parameter int unsigned SET2 = int'(`ADCSQ_US_MIN_CYC(`ADCSQ_SETTLE2_US)),
  parameter int unsigned SET3 = int'(`ADCSQ_US_MIN_CYC(`ADCSQ_SETTLE3_US)),
  parameter int unsigned SET4 = int'(`ADCSQ_US_MIN_CYC(`ADCSQ_SETTLE4_US))
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // firmware settings
  input wire logic run_en,
  input wire logic [3:0] chan_sel,
  input wire logic chan_alt,
  input wire logic ref_bandgap,
  input wire logic [1:0] range_req,
  input wire logic [2:0] mode_req,
  input wire logic sample_read,
  input wire logic err_clear,
  // analog core
  output logic [`ADCSQ_NUM_CHAN-1:0] mux_chan,
  output logic mux_pad_alt,
  output logic mux_ref_bg,
  output logic [1:0] mux_range,
  output logic core_start,
  input wire logic core_valid,
  input wire logic [`ADCSQ_SAMPLE_W-1:0] core_data,
  // samples and status
  output logic [`ADCSQ_SAMPLE_W-1:0] sample_data,
  output logic [3:0] sample_chan,
  output logic sample_ready,
  output logic overrun,
  output logic conv_timeout,
  output logic chan_error,
  output logic busy
);

  localparam int SW = `ADCSQ_SAMPLE_W;
  localparam int DROP = SW - `ADCSQ_ENOB_FAST;
  localparam logic [9:0] CONV_CYC = 10'(`ADCSQ_US_MAX_CYC(`ADCSQ_CONV_US));

  // ----------------------------------------------------------------
  // mode lookups
  // ----------------------------------------------------------------
  function automatic logic [CW-1:0] period_of(input logic [2:0] m);
    case (m)
      3'h0: period_of = CW'(PER0);
      3'h1: period_of = CW'(PER1);
      3'h2: period_of = CW'(PER2);
      3'h3: period_of = CW'(PER3);
      default: period_of = CW'(PER4);
    endcase
  endfunction

  function automatic logic [CW-1:0] settle_of(input logic [2:0] m);
    case (m)
      3'h0: settle_of = CW'(SET0);
      3'h1: settle_of = CW'(SET1);
      3'h2: settle_of = CW'(SET2);
      3'h3: settle_of = CW'(SET3);
      default: settle_of = CW'(SET4);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // settings and multiplexer selects
  // ----------------------------------------------------------------
  adcsq_state_type state_reg, state_next;
  logic [3:0] chan_reg;
  logic [2:0] mode_reg;
  logic [2:0] mode_eff;
  logic [`ADCSQ_NUM_CHAN-1:0] onehot_reg;
  logic alt_reg, ref_reg;
  logic [1:0] range_reg;
  logic chan_ok, mux_load, mode_upd, settle_load;
  logic settle_done, rate_done, start_next, capture, conv_tmo;
  logic discard_reg, start_reg, ready_reg, overrun_reg, tmo_reg, chan_err_reg;
  logic busy_reg;
  logic [9:0] conv_cnt_reg;
  logic [SW-1:0] sample_reg;
  logic [3:0] sample_chan_reg;

  // codes above 4 fall back to the fastest mode, still within the rate cap
  assign mode_eff = (mode_req > 3'h4) ? 3'h4 : mode_req;
  assign chan_ok = (chan_sel < 4'(`ADCSQ_NUM_CHAN));
  assign mux_load = chan_ok && (chan_sel != chan_reg);
  // mode changes wait until no conversion is in flight
  assign mode_upd = (state_reg != ADCSQ_CONVERT) && (mode_eff != mode_reg);
  assign settle_load = mux_load || mode_upd || (state_reg == ADCSQ_IDLE && run_en);

  // [R2] [R6] channel select
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chan_reg <= `ADCSQ_RST_CHAN;
      onehot_reg <= `ADCSQ_NUM_CHAN'(1) << `ADCSQ_RST_CHAN;
      alt_reg <= 1'b0;
    end else if (ce) begin
      if (mux_load) begin
        chan_reg <= chan_sel;
        onehot_reg <= `ADCSQ_NUM_CHAN'(1) << chan_sel;
      end
      // second pad only exists on bonded pairs; never both pads at once
      if (mux_load || chan_sel == chan_reg) begin
        alt_reg <= chan_alt && (`ADCSQ_PAIR_MASK >> (chan_ok ? chan_sel : chan_reg)) != 9'h000
          && ((`ADCSQ_PAIR_MASK >> (chan_ok ? chan_sel : chan_reg)) & 9'h001) != 9'h000;
      end
    end
  end

  // [R5] [R8] reference, range and mode held steady during a conversion
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_reg <= 1'b0;
      range_reg <= `ADCSQ_RST_RANGE;
      mode_reg <= `ADCSQ_RST_MODE;
    end else if (ce && state_reg != ADCSQ_CONVERT) begin
      ref_reg <= ref_bandgap;
      // unused code 3 falls back to the widest range to protect the core
      range_reg <= (range_req == 2'h3) ? ADCSQ_RANGE_3V6 : range_req;
      mode_reg <= mode_eff;
    end
  end

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  // [R10] settling after channel or mode change
  adcsq_timer #(.W(CW)) u_settle (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .load(settle_load),
    // mode lands together with the channel unless a conversion holds it
    .cycles(settle_of((state_reg == ADCSQ_CONVERT) ? mode_reg : mode_eff)),
    .done(settle_done)
  );

  // [R4] [R9] least spacing between starts
  adcsq_timer #(.W(CW)) u_rate (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .load(start_next),
    .cycles(period_of(mode_reg)),
    .done(rate_done)
  );

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    start_next = 1'b0;
    unique case (state_reg)
      ADCSQ_IDLE: begin
        if (run_en) begin
          state_next = ADCSQ_SETTLE;
        end
      end
      ADCSQ_SETTLE: begin
        if (!run_en) begin
          state_next = ADCSQ_IDLE;
        end else if (settle_done && rate_done && !settle_load) begin
          start_next = 1'b1;
          state_next = ADCSQ_CONVERT;
        end
      end
      ADCSQ_CONVERT: begin
        if (core_valid || conv_tmo) begin
          state_next = run_en ? ADCSQ_SETTLE : ADCSQ_IDLE;
        end
      end
    endcase
  end

  // [R3] conversion watchdog
  assign conv_tmo = (state_reg == ADCSQ_CONVERT) && !core_valid
    && (conv_cnt_reg == CONV_CYC - 10'(1));
  // [R7] only words from an undisturbed conversion become samples
  assign capture = (state_reg == ADCSQ_CONVERT) && core_valid && !discard_reg && !mux_load;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ADCSQ_IDLE;
      start_reg <= 1'b0;
      busy_reg <= 1'b0;
      conv_cnt_reg <= '0;
      discard_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      start_reg <= start_next;
      busy_reg <= (state_next == ADCSQ_CONVERT);
      conv_cnt_reg <= start_next ? 10'h000 : conv_cnt_reg + 10'(1);
      // a channel change mid-conversion spoils the word in flight
      if (start_next) begin
        discard_reg <= 1'b0;
      end else if (mux_load && state_reg == ADCSQ_CONVERT) begin
        discard_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // sample path and flags
  // ----------------------------------------------------------------
  // [R1] fastest mode keeps only the effective bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sample_reg <= '0;
      sample_chan_reg <= `ADCSQ_RST_CHAN;
    end else if (ce && capture) begin
      sample_reg <= (mode_reg == 3'h4) ? {core_data[SW-1:DROP], DROP'(0)} : core_data;
      sample_chan_reg <= chan_reg;
    end
  end

  // [R11] new sample wins over a read in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ready_reg <= 1'b0;
      overrun_reg <= 1'b0;
      tmo_reg <= 1'b0;
      chan_err_reg <= 1'b0;
    end else if (ce) begin
      ready_reg <= capture || (ready_reg && !sample_read);
      overrun_reg <= (capture && ready_reg && !sample_read) || (overrun_reg && !err_clear);
      tmo_reg <= conv_tmo || (tmo_reg && !err_clear);
      chan_err_reg <= !chan_ok || (chan_err_reg && !err_clear);
    end
  end

  assign mux_chan = onehot_reg;
  assign mux_pad_alt = alt_reg;
  assign mux_ref_bg = ref_reg;
  assign mux_range = range_reg;
  assign core_start = start_reg;
  assign sample_data = sample_reg;
  assign sample_chan = sample_chan_reg;
  assign sample_ready = ready_reg;
  assign overrun = overrun_reg;
  assign conv_timeout = tmo_reg;
  assign chan_error = chan_err_reg;
  assign busy = busy_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [CW-1:0] since_start_reg, since_chg_reg;
  logic started_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      since_start_reg <= '0;
      since_chg_reg <= '0;
      started_reg <= 1'b0;
    end else if (ce) begin
      since_start_reg <= start_next ? '0 : since_start_reg + CW'(since_start_reg != '1);
      since_chg_reg <= settle_load ? '0 : since_chg_reg + CW'(since_chg_reg != '1);
      started_reg <= started_reg || start_next;
    end
  end

  sequence s_start;
    start_reg;
  endsequence

  sequence s_back_out;
    ##[1:1000] (state_reg != ADCSQ_CONVERT);
  endsequence

  property p_rate_cap;
    @(posedge clk) disable iff (!rst_n || !ce)
      // gap as counted up to the edge that launched this start
      s_start and $past(started_reg) |-> $past(since_start_reg) >= CW'(PER4 - 1);
  endproperty
  a_rate_cap: assert property (p_rate_cap) else $error("starts too close"); // [R4]

  property p_settled;
    @(posedge clk) disable iff (!rst_n || !ce)
      s_start |-> since_chg_reg >= settle_of(mode_reg);
  endproperty
  a_settled: assert property (p_settled) else $error("start before settling"); // [R10]

  property p_conv_bound;
    @(posedge clk) disable iff (!rst_n || !ce)
      s_start |-> s_back_out;
  endproperty
  a_conv_bound: assert property (p_conv_bound) else $error("conversion overran"); // [R3]

  property p_onehot;
    @(posedge clk) disable iff (!rst_n || !ce)
      $onehot(mux_chan) && (!mux_pad_alt || (`ADCSQ_PAIR_MASK & mux_chan) != 9'h000);
  endproperty
  a_onehot: assert property (p_onehot) else $error("bad channel select"); // [R2]

  property p_ref_steady;
    @(posedge clk) disable iff (!rst_n || !ce)
      busy && $past(busy) |-> $stable(mux_ref_bg);
  endproperty
  a_ref_steady: assert property (p_ref_steady) else $error("reference moved"); // [R5]

  property p_range_steady;
    @(posedge clk) disable iff (!rst_n || !ce)
      busy && $past(busy) |-> $stable(mux_range) && mux_range != 2'h3;
  endproperty
  a_range_steady: assert property (p_range_steady) else $error("range moved"); // [R8]

  property p_ready_set;
    @(posedge clk) disable iff (!rst_n || !ce)
      capture |=> sample_ready && sample_chan == $past(chan_reg);
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready not raised"); // [R11]

  property p_ready_clear;
    @(posedge clk) disable iff (!rst_n || !ce)
      sample_read && !capture |=> !sample_ready;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared"); // [R11]

  property p_fast_trunc;
    @(posedge clk) disable iff (!rst_n || !ce)
      capture && mode_reg == 3'h4 |=> sample_data[DROP-1:0] == '0;
  endproperty
  a_fast_trunc: assert property (p_fast_trunc) else $error("low bits kept"); // [R1]

endmodule

// >>> tb/adcsq_core_model.sv
// behavioural model of the analog converter core
`timescale 1ns/1ns

module adcsq_core_model (
  // clock
  input wire logic clk,
  // bench controls
  input wire logic mute,
  input wire logic slow,
  // converter side
  input wire logic core_start,
  output logic core_valid,
  output logic [15:0] core_data
);
  logic start_q = 1'b0;
  logic [15:0] word = 16'h0000;
  int cnt = -1;

  initial begin
    core_valid = 1'b0;
    core_data = 16'hffff;
  end

  // idle bus shows the inverse of the last word, never a stale copy
  always @(posedge clk) begin
    start_q <= core_start;
    core_valid <= 1'b0;
    core_data <= ~word;
    if (core_start && !start_q && !mute) begin
      cnt <= slow ? 15 : int'($urandom_range(8, 1));
    end else if (cnt == 0) begin
      word = 16'($urandom);
      core_valid <= 1'b1;
      core_data <= word;
      cnt <= -1;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// >>> tb/tb_adc_sequencer_digital_control.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ns

module tb_adc_sequencer_digital_control;
  // short counts so every mode runs in a few hundred cycles
  localparam int PER_T[5] = '{60, 50, 40, 30, 20};
  localparam int SET_T[5] = '{50, 40, 30, 20, 10};
  logic clk = 1'b0;
  logic rst_n, ce, run_en, chan_alt, ref_bandgap, sample_read, err_clear, mute, slow;
  logic [3:0] chan_sel, sample_chan;
  logic [1:0] range_req, mux_range;
  logic [2:0] mode_req;
  logic [8:0] mux_chan;
  logic [8:0] pair_mask = 9'h064;
  logic mux_pad_alt, mux_ref_bg, core_start, core_valid, sample_ready, overrun;
  logic conv_timeout, chan_error, busy, start_q;
  logic [15:0] core_data, sample_data, exp_data;
  int fail_count = 0, n_tests = 0, cyc = 0, due = 0, mark_cyc = 0, last_start = 0;
  int cur_mode = 0, per_e = 0, set_e = 0, t0 = 0, chk_on = 1, first = 0, last_per = 0;

  always #5 clk = ~clk;

  adcsq_top #(.PER0(60), .PER1(50), .PER2(40), .PER3(30), .PER4(20),
    .SET0(50), .SET1(40), .SET2(30), .SET3(20), .SET4(10)) i_dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .run_en(run_en), .chan_sel(chan_sel),
    .chan_alt(chan_alt), .ref_bandgap(ref_bandgap), .range_req(range_req),
    .mode_req(mode_req), .sample_read(sample_read), .err_clear(err_clear),
    .mux_chan(mux_chan), .mux_pad_alt(mux_pad_alt), .mux_ref_bg(mux_ref_bg),
    .mux_range(mux_range), .core_start(core_start), .core_valid(core_valid),
    .core_data(core_data), .sample_data(sample_data), .sample_chan(sample_chan),
    .sample_ready(sample_ready), .overrun(overrun), .conv_timeout(conv_timeout),
    .chan_error(chan_error), .busy(busy));

  adcsq_core_model i_core (.clk(clk), .mute(mute), .slow(slow), .core_start(core_start),
    .core_valid(core_valid), .core_data(core_data));

  task automatic check(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic stop_test;
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  function automatic bit flag(input int w);
    case (w)
      0: return busy === 1'b0;
      1: return sample_ready === 1'b1;
      2: return core_valid === 1'b1;
      3: return conv_timeout === 1'b1;
      default: return core_start === 1'b1;
    endcase
  endfunction

  task automatic wait_for(input int w, input int lim);
    int i;
    for (i = 0; i < lim && !flag(w); i++) begin
      @(negedge clk);
    end
    if (!flag(w)) begin
      check(1'b0, "wait ran out");
      stop_test();
    end
  endtask

  // reference, range and mode only land while no conversion is in flight, so stop the run first
  task automatic start_run(input int m, input int c);
    run_en = 1'b0;
    cycles(1);
    wait_for(0, 2000);
    mode_req = 3'(m);
    chan_sel = 4'(c);
    chan_alt = 1'($urandom);
    ref_bandgap = 1'($urandom);
    range_req = 2'($urandom);
    cur_mode = (m > 4) ? 4 : m;
    // the rate timer still runs on the period of the last start
    last_per = per_e;
    per_e = PER_T[cur_mode];
    set_e = SET_T[cur_mode];
    cycles(1);
    check(mux_chan === 9'(1 << c) && mux_ref_bg === ref_bandgap, "mux select");
    check(mux_range === ((range_req == 2'h3) ? 2'h0 : range_req), "range");
    run_en = 1'b1;
    mark_cyc = cyc;
    first = 1;
  endtask

  // ----------------------------------------
  // reference model of starts and samples
  // ----------------------------------------
  always @(posedge clk) begin
    if (core_start && !start_q && chk_on == 1) begin
      if (first == 1) begin
        check(cyc - mark_cyc >= set_e && cyc - last_start >= last_per
          && (cyc - mark_cyc <= set_e + 4 || cyc - last_start <= last_per + 3), "settle");
      end else begin
        check(cyc - last_start >= per_e && cyc - last_start <= per_e + 3, "rate");
      end
      first = 0;
      last_start = cyc;
    end
    start_q = core_start;
    if (due == 1) begin
      check(sample_data === exp_data && sample_chan === chan_sel, "sample");
      check(sample_ready === 1'b1, "ready");
    end
    if (due > 0) begin
      due--;
    end
    if (core_valid === 1'b1 && busy === 1'b1) begin
      exp_data = (cur_mode == 4) ? (core_data & 16'hffc0) : core_data;
      due = 1;
    end
    cyc++;
  end

  initial begin
    rst_n = 1'b0; ce = 1'b1; run_en = 1'b0; chan_sel = 4'h0; chan_alt = 1'b0;
    ref_bandgap = 1'b0; range_req = 2'h0; mode_req = 3'h0; sample_read = 1'b0;
    err_clear = 1'b0; mute = 1'b0; slow = 1'b0;
    void'($urandom(32'h6cbe));
    cycles(2);
    rst_n = 1'b1;
    cycles(1);
    check(mux_chan === 9'h001 && busy === 1'b0 && sample_ready === 1'b0, "reset");
    check(overrun === 1'b0 && chan_error === 1'b0 && conv_timeout === 1'b0, "reset flags");
    chan_alt = 1'b1;
    for (int c = 0; c < 16; c++) begin
      chan_sel = 4'(c);
      // no sample is pending, and a set beats a clear
      sample_read = 1'($urandom);
      err_clear = 1'($urandom);
      cycles(2);
      if (c < 9) begin
        check(mux_chan === 9'(1 << c) && mux_pad_alt === pair_mask[c], "channel");
      end else begin
        check(mux_chan === 9'h100 && chan_error === 1'b1, "bad channel");
      end
    end
    chan_sel = 4'h8;
    sample_read = 1'b0;
    err_clear = 1'b1;
    cycles(1);
    err_clear = 1'b0;
    cycles(1);
    check(chan_error === 1'b0, "error clear");
    // a frozen clock enable must hold the selects
    ce = 1'b0;
    chan_sel = 4'h3;
    cycles(2);
    check(mux_chan === 9'h100, "enable hold");
    ce = 1'b1;
    cycles(2);
    check(mux_chan === 9'h008, "enable run");
    for (int m = 0; m < 8; m++) begin
      start_run(m, $urandom_range(8, 0));
      slow = 1'($urandom);
      for (int k = 0; k < 3; k++) begin
        wait_for(1, 300);
        sample_read = 1'b1;
        cycles(1);
        sample_read = 1'b0;
        check(sample_ready === 1'b0, "read clears");
      end
    end
    // two slow samples left unread
    start_run(4, 1);
    slow = 1'b1;
    wait_for(2, 300);
    cycles(1);
    wait_for(2, 300);
    cycles(2);
    check(overrun === 1'b1 && sample_ready === 1'b1, "overrun");
    slow = 1'b0;
    mute = 1'b1;
    start_run(4, 0);
    chk_on = 0;
    wait_for(4, 300);
    t0 = cyc;
    wait_for(3, 1200);
    check(cyc - t0 >= 998 && cyc - t0 <= 1003, "timeout");
    run_en = 1'b0;
    mute = 1'b0;
    err_clear = 1'b1;
    cycles(1);
    err_clear = 1'b0;
    cycles(1);
    check(conv_timeout === 1'b0 && overrun === 1'b0, "flags clear");
    stop_test();
  end
endmodule
